// File: common/rdt_pkg.sv
`default_nettype none

package rdt_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int unsigned DATA_W = 32;
  localparam int unsigned STAT_W = 32;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_HZ          = 50000000;
  localparam int unsigned TIME_BASE_US    = 1000;
  localparam int unsigned TICK_CYCLES     = (CLK_HZ / 1000000) * TIME_BASE_US;
  localparam int unsigned WRAP_MINUTES    = 69;
  localparam int unsigned EXAMPLE_2S_PRE  = 2000;

  // ==========================================================================
  // Status field positions and reset values
  // ==========================================================================
  localparam int unsigned ST_EVAL_ERR_BIT  = 0;
  localparam int unsigned ST_BAD_TARGET_BIT = 1;
  localparam logic [DATA_W-1:0] ACC_RST    = 32'h0000_0000;
  localparam logic [DATA_W-1:0] TARGET_MAX = 32'h7FFF_FFFF;
  localparam logic [STAT_W-1:0] STAT_RST   = 32'h0000_0000;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic              run_gate_in;
    logic              count_gate;
    logic              reset_req;
    logic              prescan;
    logic              postscan;
    logic              first_scan;
    logic [DATA_W-1:0] target;
  } rdt_eval_req_t;

  typedef struct packed {
    logic              valid_result_out;
    logic              run_gate_copy;
    logic              timer_enabled_flag;
    logic              timing_flag;
    logic              done_flag;
    logic [DATA_W-1:0] elapsed;
    logic [STAT_W-1:0] status;
  } rdt_eval_rsp_t;

  typedef enum logic [1:0] {
    RDT_IDLE,
    RDT_TIMING,
    RDT_DONE
  } rdt_state_t;

endpackage

`default_nettype wire

// File: src/rdt_time_ref.sv
`timescale 1ns/1ns
`default_nettype none

// Free-running millisecond time reference instantiated inside each timer instance
module rdt_time_ref (
  input  wire logic                      clock,
  input  wire logic                      srst,
  input  wire logic                      ce,
  output logic [rdt_pkg::DATA_W-1:0]     now_ms
);

  logic [15:0]                 div_ff;
  logic [rdt_pkg::DATA_W-1:0]  ms_ff;
  logic                        tick;

  assign tick   = (div_ff == 16'((rdt_pkg::TICK_CYCLES) - 1));
  assign now_ms = ms_ff;

  // ==========================================================================
  // Divider
  // ==========================================================================
  always_ff @(posedge clock) begin
    if (srst) begin
      div_ff <= 16'h0000;
    end else if (ce) begin
      div_ff <= tick ? 16'h0000 : div_ff + 16'h0001;
    end
  end

  // ==========================================================================
  // Millisecond counter
  // ==========================================================================
  always_ff @(posedge clock) begin
    if (srst) begin
      ms_ff <= rdt_pkg::ACC_RST;
    end else if (ce && tick) begin
      ms_ff <= ms_ff + 32'h0000_0001;
    end
  end

endmodule // rdt_time_ref

`default_nettype wire

// File: src/rdt_timer.sv
// Overview of operation
// - Run gate low: no evaluation, valid and run gate copy cleared
// - Accumulate only while count gate asserted
// - Target counted in one millisecond units
// - Reset clears flags and elapsed total
// - Enabled flag shows timer function enabled
// - Timing flag high while accumulating
// - Done when elapsed total reaches target
// - Status bit 0 on any error
// - Status bit 1 on bad target
// - Stop at gate removal or target
// - Time base fixed at one millisecond
// - Restart from zero after reset release
// - Add time difference, store current time
// - Evaluate running timer within 69 minutes
// - Prescan, postscan, gate low clear valid
// - Run gate high sets valid unless target bad without reset or first scan, evaluates
// - First scan clears flags and total
// - Valid output only on valid result
`timescale 1ns/1ns
`default_nettype none

module rdt_timer (
  input  wire logic                   clock,
  input  wire logic                   srst,
  input  wire logic                   ce,
  input  wire logic                   eval_strobe,
  input  wire rdt_pkg::rdt_eval_req_t req,
  output rdt_pkg::rdt_eval_rsp_t      rsp,
  output logic                        eval_done,
  output logic [rdt_pkg::DATA_W-1:0]  time_now
);

  // ==========================================================================
  // Time reference
  // ==========================================================================
  logic [rdt_pkg::DATA_W-1:0] now_ms;

  rdt_time_ref u_time_ref (
    .clock  (clock),
    .srst   (srst),
    .ce     (ce),
    .now_ms (now_ms)
  );

  assign time_now = now_ms;

  // ==========================================================================
  // State
  // ==========================================================================
  rdt_pkg::rdt_state_t        state_ff;
  rdt_pkg::rdt_state_t        nxt_state;
  logic [rdt_pkg::DATA_W-1:0] acc_ff;
  logic [rdt_pkg::DATA_W-1:0] nxt_acc;
  logic [rdt_pkg::DATA_W-1:0] last_ff;
  logic [rdt_pkg::DATA_W-1:0] nxt_last;
  logic                       en_ff;
  logic                       nxt_en;
  logic                       tt_ff;
  logic                       nxt_tt;
  logic                       dn_ff;
  logic                       nxt_dn;
  logic                       valid_ff;
  logic                       nxt_valid;
  logic                       rgc_ff;
  logic                       nxt_rgc;
  logic [rdt_pkg::STAT_W-1:0] stat_ff;
  logic [rdt_pkg::STAT_W-1:0] nxt_stat;
  logic                       done_ff;

  // Target check decoded in one place
  function automatic logic target_ok(input logic [rdt_pkg::DATA_W-1:0] t);
    target_ok = (t <= rdt_pkg::TARGET_MAX);
  endfunction

  logic                       scan_idle;
  logic                       run;
  logic                       bad_target;
  logic [rdt_pkg::DATA_W-1:0] delta;
  logic [rdt_pkg::DATA_W:0]   sum;
  logic [rdt_pkg::DATA_W-1:0] sum_sat;

  assign scan_idle  = req.prescan | req.postscan | ~req.run_gate_in;
  assign run        = eval_strobe & ~scan_idle;
  assign bad_target = ~target_ok(req.target);
  // Wrap-safe difference; the sequencer must revisit within the wrap span
  assign delta      = now_ms - last_ff;
  assign sum        = {1'b0, acc_ff} + {1'b0, delta};
  assign sum_sat    = (sum[rdt_pkg::DATA_W] || sum[rdt_pkg::DATA_W-1:0] > rdt_pkg::TARGET_MAX)
                      ? rdt_pkg::TARGET_MAX : sum[rdt_pkg::DATA_W-1:0];

  // ==========================================================================
  // Evaluation algorithm
  // ==========================================================================
  always_comb begin
    nxt_state = state_ff;
    nxt_acc   = acc_ff;
    nxt_last  = last_ff;
    nxt_en    = en_ff;
    nxt_tt    = tt_ff;
    nxt_dn    = dn_ff;
    nxt_valid = valid_ff;
    nxt_rgc   = rgc_ff;
    nxt_stat  = stat_ff;
    if (eval_strobe && scan_idle) begin
      nxt_valid = 1'b0;
      nxt_rgc   = 1'b0;
    end else if (run) begin
      nxt_rgc   = 1'b1;
      nxt_last  = now_ms;
      nxt_stat  = rdt_pkg::STAT_RST;
      if (req.first_scan || req.reset_req) begin
        nxt_en    = 1'b0;
        nxt_tt    = 1'b0;
        nxt_dn    = 1'b0;
        nxt_acc   = rdt_pkg::ACC_RST;
        nxt_state = rdt_pkg::RDT_IDLE;
        nxt_valid = 1'b1;
      end else if (bad_target) begin
        nxt_stat[rdt_pkg::ST_EVAL_ERR_BIT]   = 1'b1;
        nxt_stat[rdt_pkg::ST_BAD_TARGET_BIT] = 1'b1;
        nxt_tt    = 1'b0;
        nxt_valid = 1'b0;
      end else begin
        nxt_valid = 1'b1;
        nxt_en    = req.count_gate;
        case (state_ff)
          rdt_pkg::RDT_IDLE: begin
            // Fresh start: previous time taken now, no time yet added
            if (req.count_gate) begin
              nxt_state = (acc_ff >= req.target) ? rdt_pkg::RDT_DONE : rdt_pkg::RDT_TIMING;
            end
          end
          rdt_pkg::RDT_TIMING: begin
            if (req.count_gate) begin
              nxt_acc = sum_sat;
              if (sum_sat >= req.target) begin
                nxt_state = rdt_pkg::RDT_DONE;
              end
            end else begin
              nxt_state = rdt_pkg::RDT_IDLE;
            end
          end
          rdt_pkg::RDT_DONE: begin
            if (!req.count_gate) begin
              nxt_state = rdt_pkg::RDT_IDLE;
            end else if (acc_ff < req.target) begin
              nxt_state = rdt_pkg::RDT_TIMING;
            end
          end
          default: begin
            nxt_state = rdt_pkg::RDT_IDLE;
          end
        endcase
        nxt_tt = (nxt_state == rdt_pkg::RDT_TIMING);
        nxt_dn = (nxt_acc >= req.target);
      end
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge clock) begin
    if (srst) begin
      state_ff <= rdt_pkg::RDT_IDLE;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      acc_ff <= rdt_pkg::ACC_RST;
    end else if (ce) begin
      acc_ff <= nxt_acc;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      last_ff <= rdt_pkg::ACC_RST;
    end else if (ce) begin
      last_ff <= nxt_last;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      en_ff <= 1'b0;
    end else if (ce) begin
      en_ff <= nxt_en;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      tt_ff <= 1'b0;
    end else if (ce) begin
      tt_ff <= nxt_tt;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      dn_ff <= 1'b0;
    end else if (ce) begin
      dn_ff <= nxt_dn;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      valid_ff <= 1'b0;
    end else if (ce) begin
      valid_ff <= nxt_valid;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rgc_ff <= 1'b0;
    end else if (ce) begin
      rgc_ff <= nxt_rgc;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      stat_ff <= rdt_pkg::STAT_RST;
    end else if (ce) begin
      stat_ff <= nxt_stat;
    end
  end

  // Completion pulse follows every accepted strobe, evaluating or not
  always_ff @(posedge clock) begin
    if (srst) begin
      done_ff <= 1'b0;
    end else if (ce) begin
      done_ff <= eval_strobe;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  always_comb begin
    rsp.valid_result_out   = valid_ff;
    rsp.run_gate_copy      = rgc_ff;
    rsp.timer_enabled_flag = en_ff;
    rsp.timing_flag        = tt_ff;
    rsp.done_flag          = dn_ff;
    rsp.elapsed            = acc_ff;
    rsp.status             = stat_ff;
  end

  assign eval_done = done_ff;

endmodule // rdt_timer

`default_nettype wire

// File: verif/rdt_timer_sva.sv
`timescale 1ns/1ns
`default_nettype none
// ====
// Evaluation checker
module rdt_timer_sva (
  input wire logic                       clock,
  input wire logic                       srst,
  input wire logic                       ce,
  input wire logic                       eval_strobe,
  input wire rdt_pkg::rdt_eval_req_t     req,
  input wire rdt_pkg::rdt_eval_rsp_t     rsp,
  input wire logic                       eval_done,
  input wire logic [rdt_pkg::DATA_W-1:0] time_now
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  wire logic take = ce && eval_strobe;
  wire logic run  = take && req.run_gate_in && !req.prescan && !req.postscan;
  wire logic zap  = run && !req.target[31] && (req.reset_req || req.first_scan);
  wire logic ok   = run && !req.target[31] && !req.reset_req && !req.first_scan;
  done_pulse_a: assert property (take |=> eval_done)
    else $error("completion pulse missing");
  idle_hold_a: assert property (!take |=> $stable(rsp) && !(eval_done && $past(ce)))
    else $error("outputs moved without evaluation");
  gate_low_a: assert property (take && !run |=> !rsp.valid_result_out && !rsp.run_gate_copy && $stable(rsp.elapsed))
    else $error("gate low evaluation wrong");
  bad_target_a: assert property (run && req.target[31] && !req.reset_req && !req.first_scan |=>
    rsp.status == 32'h3 && !rsp.valid_result_out)
    else $error("bad target not flagged");
  reset_clear_a: assert property (zap |=> rsp.elapsed == 32'h0 && rsp.valid_result_out && !rsp.done_flag)
    else $error("reset evaluation wrong");
  done_cmp_a: assert property (ok |=> rsp.done_flag == (rsp.elapsed >= $past(req.target)))
    else $error("done flag disagrees with total");
  valid_ok_a: assert property (ok |=> rsp.valid_result_out && rsp.run_gate_copy && rsp.status == 32'h0)
    else $error("valid evaluation not reported");
  no_count_a: assert property (ok && !req.count_gate |=> !rsp.timing_flag && $stable(rsp.elapsed))
    else $error("counting without count gate");
  timing_a: assert property (rsp.timing_flag |-> rsp.timer_enabled_flag && !rsp.done_flag)
    else $error("timing flag inconsistent");
  time_step_a: assert property (time_now - $past(time_now) <= 32'h1)
    else $error("time reference jumped");
  cover property (ok && req.count_gate);
  cover property (zap);
  cover property (take && !run);
endmodule // rdt_timer_sva

bind rdt_timer rdt_timer_sva u_sva (.clock(clock), .srst(srst), .ce(ce), .eval_strobe(eval_strobe),
  .req(req), .rsp(rsp), .eval_done(eval_done), .time_now(time_now));
`default_nettype wire

// File: verif/rdt_scan_seq.sv
`timescale 1ns/1ns
`default_nettype none
// ====
// Scan sequencer model
module rdt_scan_seq (
  input  wire logic                   clock,
  output logic                        eval_strobe,
  output rdt_pkg::rdt_eval_req_t      req
);
  initial begin
    eval_strobe = 1'b0;
    req         = '0;
  end
  // One evaluation, request scrambled once taken; scans far inside the wrap span
  task automatic scan(input rdt_pkg::rdt_eval_req_t r);
    @(posedge clock);
    eval_strobe <= 1'b1;
    req         <= r;
    @(posedge clock);
    eval_strobe <= 1'b0;
    req         <= ~r;
    #1;
  endtask
endmodule // rdt_scan_seq
`default_nettype wire

// File: verif/resettable_on_delay_timer_test.sv
`timescale 1ns/1ns
`default_nettype none
module resettable_on_delay_timer_test;
  logic                       clock;
  logic                       srst;
  logic                       ce;
  logic                       eval_strobe;
  logic                       eval_done;
  rdt_pkg::rdt_eval_req_t     req;
  rdt_pkg::rdt_eval_rsp_t     rsp;
  logic [rdt_pkg::DATA_W-1:0] time_now;
  logic [rdt_pkg::DATA_W-1:0] t0;
  int                         n_fail = 0;
  int                         total_checks = 0;

  rdt_timer dut (.clock(clock), .srst(srst), .ce(ce), .eval_strobe(eval_strobe), .req(req), .rsp(rsp),
    .eval_done(eval_done), .time_now(time_now));
  rdt_scan_seq seq (.clock(clock), .eval_strobe(eval_strobe), .req(req));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // ====
  // Helpers
  function automatic rdt_pkg::rdt_eval_req_t mk(input logic cg, rr, fs, input logic [31:0] tgt);
    return '{1'b1, cg, rr, 1'b0, 1'b0, fs, tgt};
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Flags are {eval_done, valid, enabled, timing, done}
  task automatic chk_fl(input string nm, input logic [4:0] fl, input logic [31:0] acc);
    chk(nm, {27'h0, fl}, {27'h0, eval_done, rsp.valid_result_out, rsp.timer_enabled_flag, rsp.timing_flag,
      rsp.done_flag});
    chk(nm, acc, rsp.elapsed);
  endtask
  // ====
  // Scenarios
  task automatic t_run();
    int i;
    seq.scan(mk(1'b1, 1'b0, 1'b0, 32'h1));
    t0 = time_now;
    chk_fl("start", 5'h1E, 32'h0);
    for (i = 0; i < 60000 && time_now === t0; i++) begin
      @(posedge clock);
      #1;
    end
    if (time_now !== t0 + 32'h1) begin
      n_fail++;
      $display("[FAIL] time_now expected %h seen %h", t0 + 32'h1, time_now);
      give_verdict();
    end
    seq.scan(mk(1'b1, 1'b0, 1'b0, 32'h1));
    chk_fl("finish", 5'h1D, 32'h1);
    seq.scan(mk(1'b1, 1'b0, 1'b0, 32'h1));
    chk_fl("frozen", 5'h1D, 32'h1);
    $display("t_run done");
  endtask
  task automatic t_gate();
    rdt_pkg::rdt_eval_req_t r;
    for (int k = 0; k < 3; k++) begin
      r = mk(1'b1, 1'b0, 1'b0, 32'h1);
      r.run_gate_in = (k != 0);
      r.prescan = (k == 1);
      r.postscan = (k == 2);
      seq.scan(r);
      chk("gate valid", 32'h0, {31'h0, rsp.valid_result_out});
      chk("gate copy", 32'h0, {31'h0, rsp.run_gate_copy});
      chk("gate total", 32'h1, rsp.elapsed);
    end
    @(posedge clock);
    ce <= 1'b0;
    seq.scan(mk(1'b1, 1'b0, 1'b0, 32'h1));
    chk("ce low", 32'h0, {31'h0, eval_done});
    chk("ce low valid", 32'h0, {31'h0, rsp.valid_result_out});
    @(posedge clock);
    ce <= 1'b1;
    $display("t_gate done");
  endtask
  task automatic t_target();
    seq.scan(mk(1'b1, 1'b0, 1'b0, 32'h8000_0000));
    chk("bad status", 32'h3, rsp.status);
    chk("bad valid", 32'h0, {31'h0, rsp.valid_result_out});
    seq.scan(mk(1'b1, 1'b0, 1'b0, 32'h7FFF_FFFF));
    chk_fl("max target", 5'h1E, 32'h1);
    seq.scan(mk(1'b0, 1'b0, 1'b0, 32'h1));
    chk_fl("no count", 5'h19, 32'h1);
    $display("t_target done");
  endtask
  task automatic t_restart();
    seq.scan(mk(1'b1, 1'b1, 1'b0, 32'h1));
    chk_fl("reset req", 5'h18, 32'h0);
    seq.scan(mk(1'b1, 1'b0, 1'b1, 32'h1));
    chk_fl("first scan", 5'h18, 32'h0);
    seq.scan(mk(1'b1, 1'b0, 1'b0, 32'h0));
    chk("zero target", 32'h1, {31'h0, rsp.done_flag});
    $display("t_restart done");
  endtask

  initial begin
    srst = 1'b1;
    ce   = 1'b1;
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    #1;
    chk("reset rsp", 32'h1, {31'h0, rsp === '0});
    chk("reset time", 32'h0, time_now);
    t_run();
    t_gate();
    t_target();
    t_restart();
    give_verdict();
  end
endmodule // resettable_on_delay_timer_test
`default_nettype wire
